// ==== include/dhi_pkg.sv ====
// Constants and types shared by the display host controller
package dhi_pkg;
    // Clock and timing
    localparam int CLK_NS = 50;
    localparam int STRB_NS = 300;
    localparam int SCK_HALF_NS = 250;
    localparam int DOT_HALF_NS = 200;
    localparam int RST_LOW_NS = 10000;
    localparam logic [7:0] STRB_CYC = 8'((STRB_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] SCK_HALF_CYC = 8'((SCK_HALF_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] DOT_HALF_CYC = 8'((DOT_HALF_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] RST_CYC = 8'((RST_LOW_NS + CLK_NS - 1) / CLK_NS);
    // Mode input field positions
    localparam int MODE_NARROW_BIT = 0;
    localparam int MODE_WIDE_BIT = 3;
    // Serial frame
    localparam logic [4:0] SER_PREFIX = 5'h0e;
    localparam logic [4:0] SER_BITS = 5'd24;
    // Pixel bus width codes
    localparam logic [1:0] PIX_W18 = 2'h0;
    localparam logic [1:0] PIX_W16 = 2'h1;
    localparam logic [1:0] PIX_W6 = 2'h2;
    // Lane masks and idle values
    localparam logic [17:0] LANES_18 = 18'h3ffff;
    localparam logic [17:0] LANES_16 = 18'h3fdfe;
    localparam logic [17:0] LANES_9 = 18'h3fe00;
    localparam logic [17:0] LANES_8 = 18'h3fc00;
    localparam logic [17:0] OE_SER = 18'h3fffe;
    // Interface kind decoded from the mode inputs
    typedef enum logic [1:0] {BUS_68, BUS_80, BUS_SPI, BUS_NONE} dhi_bus_t;
endpackage

// ==== src/dhi_host.sv ====
// Host controller for the display panel system bus and pixel port
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Top mode input low: 000/001 68-type 16/8, 010/011 80-type 16/8, 10x serial.
// - Top mode input high: 68-type 18/9, 80-type 18/9, 10x differential link (host refuses it with an error response).
// - Lanes: 18-bit 17-0, 16-bit 17-10 and 8-1, 9-bit 17-9, 8-bit 17-10.
// - Accesses count only while chip select is low.
// - Register select low means index or status, high means control or memory.
// - 68-type: direction low writes, high reads; enable qualifies the access.
// - Serial input sampled on clock rise; output shifted on clock fall.
// - Active-low reset initialises the device, applied after power is stable.
// - Pixel lanes: 18-bit 17-0, 16-bit 17-13 and 11-1, 6-bit 17-12.
// - First memory read word is invalid; host discards it on 68-type and 80-type reads, not on serial reads.
module dhi_host
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // User commands
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic cmd_rs_i,
    input wire logic [17:0] cmd_data_i,
    output logic cmd_ready_o,
    output logic rsp_valid_o,
    output logic [17:0] rsp_data_o,
    output logic rsp_err_o,
    // Configuration
    input wire logic [3:0] cfg_mode_i,
    input wire logic pwr_stable_i,
    input wire logic rst_req_i,
    input wire logic [1:0] cfg_pix_width_i,
    input wire logic cfg_enable_pol_i,
    input wire logic cfg_vs_pol_i,
    input wire logic cfg_hs_pol_i,
    input wire logic cfg_dot_pol_i,
    // Pixel stream
    input wire logic pix_valid_i,
    input wire logic [17:0] pix_data_i,
    input wire logic pix_frame_i,
    input wire logic pix_line_i,
    output logic pix_ready_o,
    // Device system pins
    output logic mode_sel_top_o,
    output logic mode_sel_two_o,
    output logic mode_sel_one_o,
    output logic mode_sel_low_or_idbit_o,
    output logic reset_n_o,
    output logic chip_sel_n_o,
    output logic reg_select_o,
    output logic write_strobe_n_o,
    output logic read_strobe_n_o,
    output logic [17:0] host_data_lanes_o,
    output logic [17:0] host_data_lanes_oe_n_o,
    input wire logic [17:0] host_data_lanes_i,
    // Device pixel pins
    output logic dot_clock_o,
    output logic enable_o,
    output logic frame_sync_o,
    output logic line_sync_o,
    output logic [17:0] pixel_bus_o
);

    typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_SER, ST_RESP} dhi_state_t;

    // ==========================================================
    // Helpers
    function automatic dhi_pkg::dhi_bus_t bus_kind(input logic [3:0] m);
        if (!m[2])
            bus_kind = m[1] ? dhi_pkg::BUS_80 : dhi_pkg::BUS_68;
        else if (!m[3] && !m[1])
            bus_kind = dhi_pkg::BUS_SPI;
        else
            bus_kind = dhi_pkg::BUS_NONE;
    endfunction

    function automatic logic [17:0] lane_mask(input logic [3:0] m);
        if (m[dhi_pkg::MODE_WIDE_BIT])
            lane_mask = m[dhi_pkg::MODE_NARROW_BIT] ? dhi_pkg::LANES_9 : dhi_pkg::LANES_18;
        else
            lane_mask = m[dhi_pkg::MODE_NARROW_BIT] ? dhi_pkg::LANES_8 : dhi_pkg::LANES_16;
    endfunction

    function automatic logic [17:0] pack_db(input logic [3:0] m, input logic b,
        input logic [17:0] d);
        if (m[dhi_pkg::MODE_WIDE_BIT] && !m[dhi_pkg::MODE_NARROW_BIT])
            pack_db = d;
        else if (m[dhi_pkg::MODE_WIDE_BIT])
            pack_db = {(b ? d[8:0] : d[17:9]), 9'h000};
        else if (!m[dhi_pkg::MODE_NARROW_BIT])
            pack_db = {d[15:8], 1'b0, d[7:0], 1'b0};
        else
            pack_db = {(b ? d[7:0] : d[15:8]), 10'h000};
    endfunction

    function automatic logic [17:0] unpack_db(input logic [3:0] m, input logic b,
        input logic [17:0] l, input logic [17:0] p);
        if (m[dhi_pkg::MODE_WIDE_BIT] && !m[dhi_pkg::MODE_NARROW_BIT])
            unpack_db = l;
        else if (m[dhi_pkg::MODE_WIDE_BIT])
            unpack_db = b ? {p[17:9], l[17:9]} : {l[17:9], 9'h000};
        else if (!m[dhi_pkg::MODE_NARROW_BIT])
            unpack_db = {2'h0, l[17:10], l[8:1]};
        else
            unpack_db = b ? {2'h0, p[15:8], l[17:10]} : {2'h0, l[17:10], 8'h00};
    endfunction

    function automatic logic [17:0] pack_pd(input logic [1:0] w, input logic [1:0] b,
        input logic [17:0] d);
        if (w == dhi_pkg::PIX_W16)
            pack_pd = {d[15:11], 1'b0, d[10:0], 1'b0};
        else if (w == dhi_pkg::PIX_W6)
            pack_pd = {(b == 2'h0 ? d[17:12] : (b == 2'h1 ? d[11:6] : d[5:0])), 12'h000};
        else
            pack_pd = d;
    endfunction

    // ==========================================================
    // Input synchronisers
    logic [17:0] lanes_meta;
    logic [17:0] lanes_sync;
    logic pwr_meta;
    logic pwr_sync;

    always_ff @(posedge core_clk_i)
    begin
        lanes_meta <= host_data_lanes_i;
        lanes_sync <= lanes_meta;
        pwr_meta <= pwr_stable_i;
        pwr_sync <= pwr_meta;
    end

    // ==========================================================
    // Device reset sequencer
    logic [7:0] rcnt;

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i || !pwr_sync || rst_req_i)
        begin
            rcnt <= 8'h00;
            reset_n_o <= 1'b0;
        end
        else if (!reset_n_o)
        begin
            if (rcnt == dhi_pkg::RST_CYC - 8'h01)
                reset_n_o <= 1'b1;
            else
                rcnt <= rcnt + 8'h01;
        end
    end

    // ==========================================================
    // Access sequencer
    dhi_state_t state;
    dhi_pkg::dhi_bus_t bus;
    logic [3:0] mode;
    logic [7:0] cnt;
    logic beat;
    logic dummy;
    logic need_dummy;
    logic op_wr;
    logic op_rs;
    logic [17:0] op_data;
    logic [23:0] shreg;
    logic [14:0] rshift;
    logic sck;
    logic [4:0] bit_cnt;

    assign bus = bus_kind(mode);
    assign cmd_ready_o = (state == ST_IDLE) && reset_n_o;
    assign rsp_valid_o = (state == ST_RESP);

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            mode <= 4'h0;
        else if (state == ST_IDLE)
            mode <= cfg_mode_i;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i || !reset_n_o)
        begin
            state <= ST_IDLE;
            cnt <= 8'h00;
            beat <= 1'b0;
            dummy <= 1'b0;
            need_dummy <= 1'b1;
            op_wr <= 1'b0;
            op_rs <= 1'b0;
            op_data <= 18'h00000;
            rsp_data_o <= 18'h00000;
            rsp_err_o <= 1'b0;
            shreg <= 24'h000000;
            rshift <= 15'h0000;
            sck <= 1'b1;
            bit_cnt <= 5'h00;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (cmd_valid_i)
                    begin
                        op_wr <= cmd_write_i;
                        op_rs <= cmd_rs_i;
                        op_data <= cmd_data_i;
                        cnt <= 8'h00;
                        beat <= 1'b0;
                        rsp_err_o <= 1'b0;
                        sck <= 1'b1;
                        bit_cnt <= 5'h00;
                        if (bus == dhi_pkg::BUS_NONE)
                        begin
                            rsp_err_o <= 1'b1;
                            state <= ST_RESP;
                        end
                        else if (bus == dhi_pkg::BUS_SPI)
                        begin
                            shreg <= {dhi_pkg::SER_PREFIX, mode[0], cmd_rs_i, !cmd_write_i,
                                cmd_data_i[15:0]};
                            state <= ST_SER;
                        end
                        else
                        begin
                            dummy <= !cmd_write_i && cmd_rs_i && need_dummy;
                            state <= ST_SETUP;
                        end
                    end
                end
                ST_SETUP:
                begin
                    cnt <= (cnt == dhi_pkg::STRB_CYC - 8'h01) ? 8'h00 : cnt + 8'h01;
                    if (cnt == dhi_pkg::STRB_CYC - 8'h01)
                        state <= ST_PULSE;
                end
                ST_PULSE:
                begin
                    cnt <= (cnt == dhi_pkg::STRB_CYC - 8'h01) ? 8'h00 : cnt + 8'h01;
                    if (cnt == dhi_pkg::STRB_CYC - 8'h01)
                    begin
                        if (!op_wr)
                            rsp_data_o <= unpack_db(mode, beat, lanes_sync, rsp_data_o);
                        state <= ST_HOLD;
                    end
                end
                ST_HOLD:
                begin
                    cnt <= (cnt == dhi_pkg::STRB_CYC - 8'h01) ? 8'h00 : cnt + 8'h01;
                    if (cnt == dhi_pkg::STRB_CYC - 8'h01)
                    begin
                        if (mode[dhi_pkg::MODE_NARROW_BIT] && !beat)
                        begin
                            beat <= 1'b1;
                            state <= ST_SETUP;
                        end
                        else if (dummy)
                        begin
                            dummy <= 1'b0;
                            beat <= 1'b0;
                            state <= ST_SETUP;
                        end
                        else
                            state <= ST_RESP;
                    end
                end
                ST_SER:
                begin
                    if (cnt == dhi_pkg::SCK_HALF_CYC - 8'h01)
                    begin
                        cnt <= 8'h00;
                        sck <= !sck;
                        if (sck)
                        begin
                            if (bit_cnt != 5'h00)
                                shreg <= {shreg[22:0], 1'b0};
                        end
                        else
                        begin
                            rshift <= {rshift[13:0], lanes_sync[1]};
                            bit_cnt <= bit_cnt + 5'h01;
                            if (bit_cnt == dhi_pkg::SER_BITS - 5'h01)
                            begin
                                if (!op_wr)
                                    rsp_data_o <= {2'h0, rshift[14:0], lanes_sync[1]};
                                state <= ST_RESP;
                            end
                        end
                    end
                    else
                        cnt <= cnt + 8'h01;
                end
                ST_RESP:
                begin
                    if (op_wr)
                        need_dummy <= 1'b1;
                    else if (op_rs)
                        need_dummy <= 1'b0;
                    state <= ST_IDLE;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // System pin drivers
    logic act;
    logic pulse;

    assign act = (state == ST_SETUP) || (state == ST_PULSE) || (state == ST_HOLD);
    assign pulse = (state == ST_PULSE);

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            {mode_sel_top_o, mode_sel_two_o, mode_sel_one_o, mode_sel_low_or_idbit_o} <= 4'h0;
            chip_sel_n_o <= 1'b1;
            reg_select_o <= 1'b0;
            write_strobe_n_o <= 1'b1;
            read_strobe_n_o <= 1'b1;
            host_data_lanes_o <= 18'h00000;
            host_data_lanes_oe_n_o <= dhi_pkg::LANES_18;
        end
        else
        begin
            {mode_sel_top_o, mode_sel_two_o, mode_sel_one_o, mode_sel_low_or_idbit_o} <= mode;
            chip_sel_n_o <= !(act || state == ST_SER);
            reg_select_o <= op_rs;
            if (bus == dhi_pkg::BUS_SPI)
                host_data_lanes_o <= {17'h00000, shreg[23]};
            else
                host_data_lanes_o <= pack_db(mode, beat, op_data);
            if (bus == dhi_pkg::BUS_SPI && state == ST_SER)
                host_data_lanes_oe_n_o <= dhi_pkg::OE_SER;
            else if (act && op_wr && bus != dhi_pkg::BUS_NONE)
                host_data_lanes_oe_n_o <= ~lane_mask(mode);
            else
                host_data_lanes_oe_n_o <= dhi_pkg::LANES_18;
            case (bus)
                dhi_pkg::BUS_68:
                begin
                    write_strobe_n_o <= !(act && op_wr);
                    read_strobe_n_o <= pulse;
                end
                dhi_pkg::BUS_80:
                begin
                    write_strobe_n_o <= !(pulse && op_wr);
                    read_strobe_n_o <= !(pulse && !op_wr);
                end
                dhi_pkg::BUS_SPI:
                begin
                    write_strobe_n_o <= sck;
                    read_strobe_n_o <= 1'b0;
                end
                default:
                begin
                    write_strobe_n_o <= 1'b1;
                    read_strobe_n_o <= 1'b1;
                end
            endcase
        end
    end

    // ==========================================================
    // Pixel port
    logic [7:0] dcnt;
    logic [1:0] pbeat;
    logic launch;
    logic plast;

    assign launch = (dcnt == dhi_pkg::DOT_HALF_CYC - 8'h01) && (!dot_clock_o == cfg_dot_pol_i);
    assign plast = (cfg_pix_width_i != dhi_pkg::PIX_W6) || (pbeat == 2'h2);
    assign pix_ready_o = launch && plast;

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            dcnt <= 8'h00;
            dot_clock_o <= 1'b0;
            pbeat <= 2'h0;
            enable_o <= 1'b0;
            frame_sync_o <= 1'b0;
            line_sync_o <= 1'b0;
            pixel_bus_o <= 18'h00000;
        end
        else
        begin
            dcnt <= (dcnt == dhi_pkg::DOT_HALF_CYC - 8'h01) ? 8'h00 : dcnt + 8'h01;
            if (dcnt == dhi_pkg::DOT_HALF_CYC - 8'h01)
                dot_clock_o <= !dot_clock_o;
            if (launch)
            begin
                enable_o <= cfg_enable_pol_i ^ !pix_valid_i;
                frame_sync_o <= (pix_valid_i && pix_frame_i) ^ !cfg_vs_pol_i;
                line_sync_o <= (pix_valid_i && pix_line_i) ^ !cfg_hs_pol_i;
                pixel_bus_o <= pack_pd(cfg_pix_width_i, pbeat, pix_data_i);
                if (pix_valid_i)
                    pbeat <= plast ? 2'h0 : pbeat + 2'h1;
            end
        end
    end

endmodule // dhi_host
`default_nettype wire

// ==== tb/dhi_host_chk.sv ====
// Port checker for the display host controller
`timescale 1ns/1ps
`default_nettype none
module dhi_host_chk
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Command side
    input wire logic cmd_valid_i,
    input wire logic cmd_ready_o,
    input wire logic rsp_valid_o,
    input wire logic rsp_err_o,
    input wire logic [3:0] cfg_mode_i,
    // Device pins
    input wire logic mode_sel_top_o,
    input wire logic mode_sel_two_o,
    input wire logic mode_sel_one_o,
    input wire logic reset_n_o,
    input wire logic chip_sel_n_o,
    input wire logic write_strobe_n_o,
    input wire logic read_strobe_n_o,
    input wire logic [17:0] host_data_lanes_o,
    input wire logic [17:0] host_data_lanes_oe_n_o
);
    // ====================
    // Helper logic
    logic [8:0] low_cnt;
    logic m68;
    logic m80;
    logic mser;
    assign m68 = !mode_sel_two_o && !mode_sel_one_o && !chip_sel_n_o;
    assign m80 = !mode_sel_two_o && mode_sel_one_o && !chip_sel_n_o;
    assign mser = mode_sel_two_o && !mode_sel_one_o && !mode_sel_top_o && !chip_sel_n_o;
    always_ff @(posedge core_clk_i)
        if (sys_rst_i || reset_n_o)
            low_cnt <= 9'h000;
        else if (low_cnt != 9'h1ff)
            low_cnt <= low_cnt + 9'h001;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    // ====================
    // Assertions
    AST_CS_RSP: assert property (rsp_valid_o |-> ##[1:2] chip_sel_n_o)
        else $error("cs not released");
    AST_NOSEL_ERR: assert property (cmd_valid_i && cmd_ready_o && cfg_mode_i[2]
        && (cfg_mode_i[1] || cfg_mode_i[3]) |-> ##[1:2] rsp_valid_o && rsp_err_o)
        else $error("bad mode accepted");
    AST_NOSEL_QUIET: assert property (rsp_valid_o && rsp_err_o
        |-> chip_sel_n_o && (&host_data_lanes_oe_n_o)) else $error("pins moved on refusal");
    AST_RD80_FREE: assert property (m80 && !read_strobe_n_o |-> &host_data_lanes_oe_n_o)
        else $error("lanes driven in read");
    AST_WR80_HOLD: assert property (m80 && $rose(write_strobe_n_o)
        |-> $stable(host_data_lanes_o) && !(&host_data_lanes_oe_n_o))
        else $error("write data moved");
    AST_WR80_LEN: assert property (m80 && $fell(write_strobe_n_o)
        |-> !write_strobe_n_o[*6] ##1 write_strobe_n_o) else $error("strobe length");
    AST_RST_LEN: assert property ($rose(reset_n_o) |-> low_cnt >= 9'd200)
        else $error("reset short");
    AST_W68_DRIVE: assert property (m68 && read_strobe_n_o && !write_strobe_n_o
        |-> !(&host_data_lanes_oe_n_o)) else $error("lanes undriven");
    AST_SER_EDGE: assert property (mser && $rose(write_strobe_n_o)
        |-> $stable(host_data_lanes_o[0])) else $error("serial data moved");
    // ====================
    // Coverage
    COV_ERR: cover property (rsp_valid_o && rsp_err_o);
    COV_W68: cover property (m68 && read_strobe_n_o && !write_strobe_n_o);
    COV_SER: cover property (mser && $rose(write_strobe_n_o));
endmodule // dhi_host_chk
bind dhi_host dhi_host_chk i_chk (.*);
`default_nettype wire

// ==== tb/dhi_dev_model.sv ====
// Behavioural model of the display device pins
`timescale 1ns/1ps
`default_nettype none
module dhi_dev_model
#(
    parameter logic [17:0] STATUS_WORD = 18'h000a5,
    parameter logic [17:0] AC_IDX = 18'h00020,
    parameter logic [17:0] MEM_IDX = 18'h00022
)
(
    // System pins
    input wire logic [2:0] mode_i,
    input wire logic reset_n_i,
    input wire logic chip_sel_n_i,
    input wire logic reg_select_i,
    input wire logic write_strobe_n_i,
    input wire logic read_strobe_n_i,
    input wire logic [17:0] lanes_i,
    output logic [17:0] lanes_o,
    // Pixel pins and polarities
    input wire logic dot_clock_i,
    input wire logic enable_i,
    input wire logic frame_sync_i,
    input wire logic [17:0] pixel_bus_i,
    input wire logic [2:0] pol_i
);
    // ====================
    // State
    logic [17:0] idx = 18'h00000;
    logic [17:0] ac = 18'h00000;
    logic [17:0] hold_rd = 18'h3ffff;
    logic [17:0] last = 18'h00000;
    logic [17:0] pix_last = 18'h00000;
    logic [17:0] mem [16];
    logic pix_sync = 1'b0;
    int pix_cnt = 0;
    logic b68, b80, rd_act;
    logic [17:0] word, rword;
    // ====================
    // Bus decode
    assign b68 = !mode_i[1] && !mode_i[0];
    assign b80 = !mode_i[1] && mode_i[0];
    assign word = mode_i[2] ? lanes_i : {2'h0, lanes_i[17:10], lanes_i[8:1]};
    assign rword = reg_select_i ? hold_rd : STATUS_WORD;
    assign rd_act = !chip_sel_n_i && reset_n_i && (b80 ? !read_strobe_n_i
        : b68 && read_strobe_n_i && write_strobe_n_i);
    assign lanes_o = !rd_act ? ~last
        : mode_i[2] ? rword : {rword[15:8], 1'b0, rword[7:0], 1'b0};
    always @(lanes_o)
        if (rd_act)
            last = lanes_o;
    task automatic take_write();
        if (!reg_select_i)
            idx = word;
        else if (idx == AC_IDX)
            ac = word;
        else if (idx == MEM_IDX)
        begin
            mem[ac[3:0]] = word;
            ac = ac + 18'h00001;
        end
    endtask
    always @(posedge write_strobe_n_i)
        if (b80 && read_strobe_n_i && !chip_sel_n_i && reset_n_i)
            take_write();
    always @(posedge read_strobe_n_i)
        if (b80 && !chip_sel_n_i && reg_select_i)
            hold_rd = mem[ac[3:0]];
    always @(negedge read_strobe_n_i)
        if (b68 && !chip_sel_n_i && reset_n_i && !write_strobe_n_i)
            take_write();
        else if (b68 && !chip_sel_n_i && reg_select_i)
            hold_rd = mem[ac[3:0]];
    always @(negedge reset_n_i)
    begin
        idx = 18'h00000;
        ac = 18'h00000;
        hold_rd = 18'h3ffff;
    end
    // ====================
    // Pixel capture
    always @(dot_clock_i)
        if (dot_clock_i != pol_i[0] && reset_n_i && enable_i == pol_i[2])
        begin
            pix_cnt = pix_cnt + 1;
            pix_last = pixel_bus_i;
            pix_sync = frame_sync_i == pol_i[1];
        end
endmodule // dhi_dev_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the display host controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ====================
    // Signals
    localparam logic [17:0] AC_IDX = 18'h00020;
    localparam logic [17:0] MEM_IDX = 18'h00022;
    localparam logic [17:0] STAT = 18'h000a5;
    localparam logic [3:0] MODES [4] = '{4'ha, 4'h8, 4'h2, 4'h0};
    localparam logic [3:0] BAD [3] = '{4'h6, 4'h7, 4'hc};
    logic core_clk_i = 1'b0, sys_rst_i = 1'b1, cmd_valid_i = 1'b0, cmd_write_i = 1'b0;
    logic cmd_rs_i = 1'b0, pwr_stable_i = 1'b1, rst_req_i = 1'b0, pix_valid_i = 1'b0;
    logic pix_frame_i = 1'b1, pix_line_i = 1'b1, en_pol = 1'b0, vs_pol = 1'b0, dot_pol = 1'b0;
    logic [17:0] cmd_data_i = 18'h00000, pix_data_i = 18'h00000;
    logic [3:0] cfg_mode_i = 4'ha;
    logic [1:0] cfg_pix_width_i = 2'h0;
    logic cmd_ready_o, rsp_valid_o, rsp_err_o, pix_ready_o, top, two, one, low;
    logic reset_n_o, cs_n, rs, wr_n, rd_n, dot, en, fs, ls;
    logic [17:0] rsp_data_o, lanes, oe_n, pixels, dev_lanes, bus_lanes;
    int failures = 0, samples_checked = 0, cycles = 0;
    assign bus_lanes = (~oe_n & lanes) | (oe_n & dev_lanes);
    // ====================
    // Design and device model
    dhi_host i_dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid_i),
        .cmd_write_i(cmd_write_i), .cmd_rs_i(cmd_rs_i), .cmd_data_i(cmd_data_i),
        .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
        .rsp_err_o(rsp_err_o), .cfg_mode_i(cfg_mode_i), .pwr_stable_i(pwr_stable_i),
        .rst_req_i(rst_req_i), .cfg_pix_width_i(cfg_pix_width_i), .cfg_enable_pol_i(en_pol),
        .cfg_vs_pol_i(vs_pol), .cfg_hs_pol_i(vs_pol), .cfg_dot_pol_i(dot_pol),
        .pix_valid_i(pix_valid_i), .pix_data_i(pix_data_i), .pix_frame_i(pix_frame_i),
        .pix_line_i(pix_line_i), .pix_ready_o(pix_ready_o), .mode_sel_top_o(top),
        .mode_sel_two_o(two), .mode_sel_one_o(one), .mode_sel_low_or_idbit_o(low),
        .reset_n_o(reset_n_o), .chip_sel_n_o(cs_n), .reg_select_o(rs), .write_strobe_n_o(wr_n),
        .read_strobe_n_o(rd_n), .host_data_lanes_o(lanes), .host_data_lanes_oe_n_o(oe_n),
        .host_data_lanes_i(bus_lanes), .dot_clock_o(dot), .enable_o(en), .frame_sync_o(fs),
        .line_sync_o(ls), .pixel_bus_o(pixels));
    dhi_dev_model i_dev (
        .mode_i({top, two, one}), .reset_n_i(reset_n_o), .chip_sel_n_i(cs_n),
        .reg_select_i(rs), .write_strobe_n_i(wr_n), .read_strobe_n_i(rd_n),
        .lanes_i(bus_lanes), .lanes_o(dev_lanes), .dot_clock_i(dot), .enable_i(en),
        .frame_sync_i(fs), .pixel_bus_i(pixels), .pol_i({en_pol, vs_pol, dot_pol}));
    // ====================
    // Clock, timeout and tasks
    always #25 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i)
    begin
        cycles++;
        if (cycles == 12000)
        begin
            failures++;
            $display("[FAIL] %0t run did not finish", $time);
            results();
        end
    end
    task automatic check(input logic [17:0] got, input logic [17:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic access(input logic wr, input logic sel, input logic [17:0] d,
        output logic [17:0] q, output logic e);
        int n;
        repeat (600) if (cmd_ready_o !== 1'b1) @(negedge core_clk_i);
        {cmd_valid_i, cmd_write_i, cmd_rs_i, cmd_data_i} = {1'b1, wr, sel, d};
        n = 0;
        do
        begin
            @(negedge core_clk_i);
            cmd_valid_i = 1'b0;
            n++;
        end
        while (rsp_valid_o !== 1'b1 && n < 2000);
        check(18'(n < 2000), 18'h00001);
        q = rsp_data_o;
        e = rsp_err_o;
    endtask
    task automatic run_mode(input logic [3:0] m);
        logic [17:0] q, w0, w1;
        logic e;
        cfg_mode_i = m;
        repeat (2) @(negedge core_clk_i);
        w0 = m[3] ? 18'h2a5c3 : 18'h0a5c3;
        w1 = m[3] ? 18'h1b4d2 : 18'h0b4d2;
        for (int k = 0; k < 2; k++)
        begin
            access(1'b1, 1'b0, AC_IDX, q, e);
            access(1'b1, 1'b1, 18'h00005, q, e);
            access(1'b1, 1'b0, MEM_IDX, q, e);
            if (k == 0)
            begin
                access(1'b1, 1'b1, w0, q, e);
                access(1'b1, 1'b1, w1, q, e);
                check(i_dev.ac, 18'h00007);
                check(i_dev.mem[6], w1);
            end
        end
        access(1'b0, 1'b1, 18'h00000, q, e);
        check(q, w0);
        access(1'b0, 1'b1, 18'h00000, q, e);
        check(q, w0);
        check(i_dev.ac, 18'h00005);
        access(1'b0, 1'b0, 18'h00000, q, e);
        check(q, STAT);
        check(18'(e), 18'h00000);
    endtask
    task automatic results();
        $display("Checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ====================
    // Main sequence
    initial
    begin
        logic [17:0] q;
        logic e;
        int c0;
        repeat (5) @(negedge core_clk_i);
        sys_rst_i = 1'b0;
        foreach (MODES[k])
            run_mode(MODES[k]);
        rst_req_i = 1'b1;
        @(negedge core_clk_i);
        rst_req_i = 1'b0;
        @(negedge core_clk_i);
        check(18'(cmd_ready_o), 18'h00000);
        access(1'b0, 1'b0, 18'h00000, q, e);
        check(i_dev.ac, 18'h00000);
        foreach (BAD[k])
        begin
            cfg_mode_i = BAD[k];
            repeat (2) @(negedge core_clk_i);
            access(1'b1, 1'b0, AC_IDX, q, e);
            check(18'(e), 18'h00001);
        end
        cfg_mode_i = 4'h5;
        repeat (2) @(negedge core_clk_i);
        access(1'b1, 1'b0, AC_IDX, q, e);
        check(18'(e), 18'h00000);
        for (int p = 0; p < 2; p++)
        begin
            {en_pol, vs_pol, dot_pol} = {3{p[0]}};
            repeat (20) @(negedge core_clk_i);
            c0 = i_dev.pix_cnt;
            pix_data_i = p[0] ? 18'h2b3c4 : 18'h1c2d3;
            pix_valid_i = 1'b1;
            repeat (100) if (pix_ready_o !== 1'b1) @(negedge core_clk_i);
            @(negedge core_clk_i);
            pix_valid_i = 1'b0;
            repeat (20) @(negedge core_clk_i);
            check(18'(i_dev.pix_cnt - c0), 18'h00001);
            check(i_dev.pix_last, pix_data_i);
            check(18'(i_dev.pix_sync), 18'h00001);
        end
        results();
    end
endmodule // tb_top
`default_nettype wire
